// ==== logic/bscp_sram_dev.sv ====
/*
  SRAM end of the burst-of-four command port: command acceptance, read
  and write burst pipelines, two-entry write buffer and storage array.
  Assumes the controller on the link keeps command spacing and beat
  timing, and that clk_en low stands for a stopped input clock.
*/
// Behaviour
// - Every accepted command moves exactly four beats.
// - Read taken when read select sampled low.
// - Write taken when write select sampled low.
// - Clock stops only after bursts; state held.
// - Same-type commands only every other edge.
// - Second of back-to-back same commands discarded.
// - Both selects after idle: read only.
// - Write select low at command edge t.
// - Two lane enables per beat gate halves.
// - Enables sampled with their own beat phase.
// - Burst addresses advance base plus zero..three.
// - Idle cycle never cuts a read burst.
// - Reads of last two writes use buffers.
`timescale 1ns/1ns
module bscp_sram_dev (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  bscp_link_if.dev link
);
  import bscp_pkg::*;

  typedef struct packed {
    logic [2:0] rd_v;
    logic [2:0][ADDR_W-1:0] rd_a;
    logic [2:0] wr_v;
    logic [2:0][ADDR_W-1:0] wr_a;
    logic [1:0][DATA_W-1:0] stg_d;
    logic [1:0][LANES-1:0] stg_en;
    bscp_wbuf_type buf0;
    bscp_wbuf_type buf1;
    logic prev_rd;
    logic prev_wr;
    logic prev_idle;
    bscp_word_type dout_rise;
    bscp_word_type dout_fall;
    logic rise_oe;
    logic fall_oe;
  } bscp_dev_state_type;

  bscp_dev_state_type st_q;
  bscp_dev_state_type st_d;
  bscp_word_type mem [MEM_DEPTH];
  logic idle_cycle;
  logic rd_acc;
  logic wr_acc;
  bscp_lane_type en_rise;
  bscp_lane_type en_fall;
  bscp_addr_type fall_addr;
  bscp_addr_type rise_addr;
  bscp_word_type mem_fall;
  bscp_word_type mem_rise;
  logic commit;

  // Newest buffer entry is merged last so that it wins lane by lane.
  function automatic bscp_word_type fwd_word(
    input bscp_wbuf_type b0,
    input bscp_wbuf_type b1,
    input bscp_addr_type a,
    input bscp_word_type arr
  );
    bscp_addr_type o0;
    bscp_addr_type o1;
    bscp_word_type w;
    bscp_word_type m;
    o0 = a - b0.base;
    o1 = a - b1.base;
    w = arr;
    if (b1.vld && o1 < BEATS) begin
      m = bscp_lane_mask(b1.en[o1[1:0]]);
      w = (w & ~m) | (b1.data[o1[1:0]] & m);
    end
    if (b0.vld && o0 < BEATS) begin
      m = bscp_lane_mask(b0.en[o0[1:0]]);
      w = (w & ~m) | (b0.data[o0[1:0]] & m);
    end
    return w;
  endfunction

  // A beat whose two lane enables are both high writes nothing.
  assign en_rise = {!link.lane1_write_enable_n[PH_RISE],
                    !link.lane0_write_enable_n[PH_RISE]};
  assign en_fall = {!link.lane1_write_enable_n[PH_FALL],
                    !link.lane0_write_enable_n[PH_FALL]};

  // Fall beats carry base+0 from stage 0 and base+2 from stage 1; rise
  // beats carry base+1 from stage 1 and base+3 from stage 2.
  assign fall_addr = st_q.rd_v[0] ? st_q.rd_a[0]
                                  : st_q.rd_a[1] + 2'h2;
  assign rise_addr = st_q.rd_v[1] ? st_q.rd_a[1] + 2'h1
                                  : st_q.rd_a[2] + 2'h3;
  assign mem_fall = mem[fall_addr];
  assign mem_rise = mem[rise_addr];

  // The oldest entry reaches the array only when a third write completes.
  assign commit = st_q.wr_v[2] && st_q.buf1.vld;

  always_comb begin
    st_d = st_q;
    idle_cycle = link.sel_rd_n && link.sel_wr_n;
    rd_acc = !link.sel_rd_n && !st_q.prev_rd;
    wr_acc = !link.sel_wr_n && !st_q.prev_wr
             && !(rd_acc && st_q.prev_idle);
    st_d.prev_rd = rd_acc;
    st_d.prev_wr = wr_acc;
    st_d.prev_idle = idle_cycle;
    // Fixed three-stage pipelines: a command cannot be cut or stretched.
    st_d.rd_v = {st_q.rd_v[1:0], rd_acc};
    st_d.rd_a = {st_q.rd_a[1:0], link.addr};
    st_d.wr_v = {st_q.wr_v[1:0], wr_acc};
    st_d.wr_a = {st_q.wr_a[1:0], link.addr};
    if (st_q.wr_v[1]) begin
      st_d.stg_d = {link.din_fall, link.din_rise};
      st_d.stg_en = {en_fall, en_rise};
    end
    if (st_q.wr_v[2]) begin
      st_d.buf1 = st_q.buf0;
      st_d.buf0.vld = 1'h1;
      st_d.buf0.base = st_q.wr_a[2];
      st_d.buf0.data = {link.din_fall, link.din_rise,
                        st_q.stg_d};
      st_d.buf0.en = {en_fall, en_rise, st_q.stg_en};
    end
    // Outputs fall back to zero and undriven between beats.
    st_d.fall_oe = st_q.rd_v[0] || st_q.rd_v[1];
    st_d.rise_oe = st_q.rd_v[1] || st_q.rd_v[2];
    st_d.dout_fall = '0;
    st_d.dout_rise = '0;
    if (st_d.fall_oe) begin
      st_d.dout_fall = fwd_word(st_q.buf0, st_q.buf1, fall_addr,
                                mem_fall);
    end
    if (st_d.rise_oe) begin
      st_d.dout_rise = fwd_word(st_q.buf0, st_q.buf1, rise_addr,
                                mem_rise);
    end
  end

  // Clock enable low freezes everything, array included.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // The array itself is not reset; only the control state is.
  always_ff @(posedge mclk) begin
    if (clk_en && commit) begin
      for (int b = 0; b < BEATS; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (st_q.buf1.en[b][l]) begin
            mem[ADDR_W'(st_q.buf1.base + b)][l*LANE_W +: LANE_W] <=
              st_q.buf1.data[b][l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  assign link.dout_rise = st_q.dout_rise;
  assign link.dout_fall = st_q.dout_fall;
  assign link.dout_rise_oe = st_q.rise_oe;
  assign link.dout_fall_oe = st_q.fall_oe;
endmodule

// ==== inc/bscp_pkg.sv ====
/*
  Shared constants and types for the burst-of-four SRAM command port.
  Assumes both ends run on one clock, mclk, and that each mclk cycle
  carries one rise-phase beat and one fall-phase beat.
*/
package bscp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned LANES = 2;
  localparam int unsigned BEATS = 4;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PH_RISE = 0;
  localparam int unsigned PH_FALL = 1;
  localparam logic SEL_IDLE = 1'h1;
  localparam logic [1:0] LANE_OFF_N = 2'h3;

  typedef logic [ADDR_W-1:0] bscp_addr_type;
  typedef logic [DATA_W-1:0] bscp_word_type;
  typedef logic [LANES-1:0] bscp_lane_type;
  typedef logic [BEATS-1:0][DATA_W-1:0] bscp_burst_type;
  typedef logic [BEATS-1:0][LANES-1:0] bscp_burst_en_type;

  typedef struct packed {
    logic vld;
    bscp_addr_type base;
    bscp_burst_type data;
    bscp_burst_en_type en;
  } bscp_wbuf_type;

  function automatic bscp_word_type bscp_lane_mask(input bscp_lane_type en);
    bscp_word_type m;
    m = '0;
    for (int l = 0; l < LANES; l++) begin
      m[l*LANE_W +: LANE_W] = {LANE_W{en[l]}};
    end
    return m;
  endfunction
endpackage

// ==== inc/bscp_link_if.sv ====
/*
  Link between the SRAM end and the controller end of the command port.
  Assumes both ends share mclk; the output enables stand for the drive
  of the read data pins, low meaning high impedance.
*/
`timescale 1ns/1ns
interface bscp_link_if;
  logic sel_rd_n;
  logic sel_wr_n;
  bscp_pkg::bscp_addr_type addr;
  bscp_pkg::bscp_word_type din_rise;
  bscp_pkg::bscp_word_type din_fall;
  logic [1:0] lane0_write_enable_n;
  logic [1:0] lane1_write_enable_n;
  bscp_pkg::bscp_word_type dout_rise;
  bscp_pkg::bscp_word_type dout_fall;
  logic dout_rise_oe;
  logic dout_fall_oe;

  modport dev (
    input sel_rd_n, sel_wr_n, addr, din_rise, din_fall,
    input lane0_write_enable_n, lane1_write_enable_n,
    output dout_rise, dout_fall, dout_rise_oe, dout_fall_oe
  );
  modport ctl (
    output sel_rd_n, sel_wr_n, addr, din_rise, din_fall,
    output lane0_write_enable_n, lane1_write_enable_n,
    input dout_rise, dout_fall, dout_rise_oe, dout_fall_oe
  );
endinterface

// ==== logic/bscp_mem_ctl.sv ====
/*
  Controller end of the burst-of-four command port: takes whole-burst
  requests from a user port, issues them on the link and gathers reads.
  Assumes the SRAM end on the link shares mclk and clk_en.
*/
`timescale 1ns/1ns
module bscp_mem_ctl (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  bscp_link_if.ctl link,
  input wire logic usr_cmd_valid,
  input wire logic usr_cmd_write,
  input wire bscp_pkg::bscp_addr_type usr_addr,
  input wire bscp_pkg::bscp_burst_type usr_wdata,
  input wire bscp_pkg::bscp_burst_en_type usr_wlane_n,
  output logic usr_cmd_ready,
  output bscp_pkg::bscp_burst_type usr_rdata,
  output logic usr_rdata_valid
);
  import bscp_pkg::*;

  typedef struct packed {
    logic ready;
    logic sel_rd_n;
    logic sel_wr_n;
    bscp_addr_type addr;
    logic [2:0] wv;
    logic [4:0] rv;
    bscp_burst_type wd;
    bscp_burst_en_type wen_n;
    bscp_word_type din_rise;
    bscp_word_type din_fall;
    logic [1:0] len0_n;
    logic [1:0] len1_n;
    bscp_word_type rb0;
    logic [2:0][DATA_W-1:0] rb_hold;
    bscp_burst_type rdata;
    logic rvalid;
  } bscp_ctl_state_type;

  bscp_ctl_state_type st_q;
  bscp_ctl_state_type st_d;
  logic take;

  always_comb begin
    st_d = st_q;
    take = usr_cmd_valid && st_q.ready;
    // One command per two edges keeps both kinds clear of the discard.
    st_d.ready = !take;
    st_d.sel_rd_n = !(take && !usr_cmd_write);
    st_d.sel_wr_n = !(take && usr_cmd_write);
    if (take) begin
      st_d.addr = usr_addr;
    end
    st_d.wv = {st_q.wv[1:0], take && usr_cmd_write};
    st_d.rv = {st_q.rv[3:0], take && !usr_cmd_write};
    if (take && usr_cmd_write) begin
      st_d.wd = usr_wdata;
      st_d.wen_n = usr_wlane_n;
    end
    // Beats 0 and 1 go out two edges after issue, beats 2 and 3 next.
    st_d.len0_n = LANE_OFF_N;
    st_d.len1_n = LANE_OFF_N;
    if (st_q.wv[1]) begin
      st_d.din_rise = st_q.wd[0];
      st_d.din_fall = st_q.wd[1];
      st_d.len0_n = {st_q.wen_n[1][0], st_q.wen_n[0][0]};
      st_d.len1_n = {st_q.wen_n[1][1], st_q.wen_n[0][1]};
    end
    if (st_q.wv[2]) begin
      st_d.din_rise = st_q.wd[2];
      st_d.din_fall = st_q.wd[3];
      st_d.len0_n = {st_q.wen_n[3][0], st_q.wen_n[2][0]};
      st_d.len1_n = {st_q.wen_n[3][1], st_q.wen_n[2][1]};
    end
    st_d.rvalid = 1'h0;
    if (st_q.rv[2]) begin
      st_d.rb0 = link.dout_fall;
    end
    if (st_q.rv[3]) begin
      st_d.rb_hold = {link.dout_fall, link.dout_rise, st_q.rb0};
    end
    if (st_q.rv[4]) begin
      st_d.rdata = {link.dout_rise, st_q.rb_hold};
      st_d.rvalid = 1'h1;
    end
  end

  // Holding state while clk_en is low only stays safe between bursts.
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= '0;
      st_q.sel_rd_n <= SEL_IDLE;
      st_q.sel_wr_n <= SEL_IDLE;
      st_q.len0_n <= LANE_OFF_N;
      st_q.len1_n <= LANE_OFF_N;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign link.sel_rd_n = st_q.sel_rd_n;
  assign link.sel_wr_n = st_q.sel_wr_n;
  assign link.addr = st_q.addr;
  assign link.din_rise = st_q.din_rise;
  assign link.din_fall = st_q.din_fall;
  assign link.lane0_write_enable_n = st_q.len0_n;
  assign link.lane1_write_enable_n = st_q.len1_n;
  assign usr_cmd_ready = st_q.ready;
  assign usr_rdata = st_q.rdata;
  assign usr_rdata_valid = st_q.rvalid;
endmodule

// ==== dv/bscp_link_checker.sv ====
/*
  Link checker for the burst-of-four command port.
  Assumes it watches the link joining the two design ends on one clock.
*/
`timescale 1ns/1ns
module bscp_link_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic sel_rd_n,
  input wire logic sel_wr_n,
  input wire logic [1:0] lane0_write_enable_n,
  input wire logic [1:0] lane1_write_enable_n,
  input wire bscp_pkg::bscp_word_type dout_rise,
  input wire bscp_pkg::bscp_word_type dout_fall,
  input wire logic dout_rise_oe,
  input wire logic dout_fall_oe
);
  import bscp_pkg::*;
  logic rd_q;
  logic rd_take;
  logic lanes_on;
  assign rd_take = clk_en && !sel_rd_n && !rd_q;
  assign lanes_on = (lane0_write_enable_n & lane1_write_enable_n) != 2'h3;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_q <= 1'h0;
    end else if (clk_en) begin
      rd_q <= rd_take;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);
  a_read_fall_beats: assert property (
    rd_take |-> ##2 dout_fall_oe [*2]) else $error("fall beats missing");
  a_read_rise_beats: assert property (
    rd_take |-> ##3 dout_rise_oe [*2]) else $error("rise beats missing");
  a_rise_undriven: assert property (
    dout_rise_oe |-> $past(rd_take, 3) || $past(rd_take, 4))
    else $error("rise pins driven without read");
  a_fall_undriven: assert property (
    dout_fall_oe |-> $past(rd_take, 2) || $past(rd_take, 3))
    else $error("fall pins driven without read");
  a_rise_zero_idle: assert property (
    !dout_rise_oe |-> dout_rise == '0) else $error("rise data not zero");
  a_fall_zero_idle: assert property (
    !dout_fall_oe |-> dout_fall == '0) else $error("fall data not zero");
  a_write_spacing: assert property (
    !sel_wr_n |=> sel_wr_n) else $error("writes on adjacent edges");
  a_read_spacing: assert property (
    !sel_rd_n |=> sel_rd_n) else $error("reads on adjacent edges");
  a_lane_window: assert property (
    lanes_on |-> !$past(sel_wr_n, 2) || !$past(sel_wr_n, 3))
    else $error("lane enable outside write beats");
endmodule

// ==== dv/tb_burst4_sram_command_port.sv ====
/*
  Bench for the command port: controller and SRAM ends on one link, plus
  a bare SRAM end driven directly to break the spacing rules on purpose.
  Assumes one clock; clk_en drops only between bursts, as a stop must.
*/
`timescale 1ns/1ns
module tb_burst4_sram_command_port;
  import bscp_pkg::*;
  logic mclk;
  logic srst;
  logic clk_en;
  logic usr_cmd_valid;
  logic usr_cmd_write;
  bscp_addr_type usr_addr;
  bscp_burst_type usr_wdata;
  bscp_burst_en_type usr_wlane_n;
  logic usr_cmd_ready;
  bscp_burst_type usr_rdata;
  logic usr_rdata_valid;
  bscp_word_type exp_mem [MEM_DEPTH];
  int mismatches;
  int compares;
  bscp_burst_type q;
  bscp_burst_type bp;
  bscp_link_if link ();
  bscp_link_if link2 ();
  bscp_mem_ctl bscp_mem_ctl_i (.mclk(mclk), .srst(srst), .clk_en(clk_en),
    .link(link), .usr_cmd_valid(usr_cmd_valid),
    .usr_cmd_write(usr_cmd_write), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_wlane_n(usr_wlane_n),
    .usr_cmd_ready(usr_cmd_ready), .usr_rdata(usr_rdata),
    .usr_rdata_valid(usr_rdata_valid));
  bscp_sram_dev bscp_sram_dev_i (.mclk(mclk), .srst(srst), .clk_en(clk_en),
    .link(link));
  bscp_sram_dev bscp_sram_dev_bare_i (.mclk(mclk), .srst(srst),
    .clk_en(clk_en), .link(link2));
  bscp_link_checker bscp_link_checker_i (.mclk(mclk), .srst(srst),
    .clk_en(clk_en), .sel_rd_n(link.sel_rd_n), .sel_wr_n(link.sel_wr_n),
    .lane0_write_enable_n(link.lane0_write_enable_n),
    .lane1_write_enable_n(link.lane1_write_enable_n),
    .dout_rise(link.dout_rise), .dout_fall(link.dout_fall),
    .dout_rise_oe(link.dout_rise_oe), .dout_fall_oe(link.dout_fall_oe));
  task automatic chk(input string what, input logic [71:0] seen,
                     input logic [71:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic results();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic issue(input logic w, input bscp_addr_type a,
                       input bscp_burst_type d, input bscp_burst_en_type ln);
    int n;
    n = 0;
    while (usr_cmd_ready !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    usr_cmd_valid = 1'h1;
    usr_cmd_write = w;
    usr_addr = a;
    usr_wdata = d;
    usr_wlane_n = ln;
    @(negedge mclk);
    usr_cmd_valid = 1'h0;
  endtask
  // The wait after a write lets it leave capture, since only completed
  // writes are forwarded to reads.
  task automatic wr(input bscp_addr_type a, input logic [7:0] s,
                    input bscp_burst_en_type ln);
    bscp_burst_type d;
    bscp_word_type m;
    for (int b = 0; b < BEATS; b++) begin
      d[b] = {s, 10'(b)};
      m = {{LANE_W{~ln[b][1]}}, {LANE_W{~ln[b][0]}}};
      exp_mem[8'(a + b)] = (exp_mem[8'(a + b)] & ~m) | (d[b] & m);
    end
    issue(1'h1, a, d, ln);
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input bscp_addr_type a);
    bscp_burst_type e;
    for (int b = 0; b < BEATS; b++) begin
      e[b] = exp_mem[8'(a + b)];
    end
    issue(1'h0, a, '0, '1);
    repeat (5) @(negedge mclk);
    chk("usr_rdata_valid", 72'(usr_rdata_valid), 72'h1);
    chk("usr_rdata", usr_rdata, e);
  endtask
  task automatic count_beats(input int cyc, input int want);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge mclk);
      #1;
      n += int'(link2.dout_fall_oe === 1'h1);
      n += int'(link2.dout_rise_oe === 1'h1);
    end
    chk("bare_beats", 72'(n), 72'(want));
  endtask
  // Drives one command on the bare end and gathers its four read beats.
  // Write beats stand in the cycle before each sampling edge.
  task automatic bare_cmd(input logic rn, input logic wn,
                          input logic [7:0] s, output bscp_burst_type r);
    @(negedge mclk);
    link2.sel_rd_n = rn;
    link2.sel_wr_n = wn;
    @(negedge mclk);
    link2.sel_rd_n = 1'h1;
    link2.sel_wr_n = 1'h1;
    @(negedge mclk);
    r[0] = link2.dout_fall;
    link2.din_rise = {s, 10'h000};
    link2.din_fall = {s, 10'h001};
    link2.lane0_write_enable_n = 2'h0;
    link2.lane1_write_enable_n = 2'h0;
    @(negedge mclk);
    r[1] = link2.dout_rise;
    r[2] = link2.dout_fall;
    link2.din_rise = {s, 10'h002};
    link2.din_fall = {s, 10'h003};
    @(negedge mclk);
    r[3] = link2.dout_rise;
    link2.lane0_write_enable_n = 2'h3;
    link2.lane1_write_enable_n = 2'h3;
  endtask
  initial begin
    mclk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  // About a hundred cycles suffice; the limit leaves ample margin.
  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    results();
  end
  initial begin
    mismatches = 0;
    compares = 0;
    srst = 1'h1;
    clk_en = 1'h1;
    usr_cmd_valid = 1'h0;
    usr_cmd_write = 1'h0;
    usr_addr = '0;
    usr_wdata = '0;
    usr_wlane_n = '1;
    link2.sel_rd_n = 1'h1;
    link2.sel_wr_n = 1'h1;
    link2.addr = 8'h10;
    link2.din_rise = '0;
    link2.din_fall = '0;
    link2.lane0_write_enable_n = 2'h3;
    link2.lane1_write_enable_n = 2'h3;
    repeat (2) @(negedge mclk);
    srst = 1'h0;
    wr(8'hFE, 8'hA5, '0);
    wr(8'h10, 8'h3C, '0);
    wr(8'hFE, 8'h5A, {2'h0, 2'h3, 2'h1, 2'h2});
    rd(8'hFE);
    rd(8'h10);
    wr(8'h80, 8'hC3, '0);
    wr(8'h80, 8'h69, {2'h1, 2'h2, 2'h0, 2'h3});
    rd(8'hFE);
    rd(8'h10);
    rd(8'h80);
    clk_en = 1'h0;
    usr_cmd_valid = 1'h1;
    repeat (4) @(negedge mclk);
    chk("stop_ready", 72'(usr_cmd_ready), 72'h1);
    chk("stop_sel_rd_n", 72'(link.sel_rd_n), 72'h1);
    usr_cmd_valid = 1'h0;
    clk_en = 1'h1;
    @(negedge mclk);
    rd(8'h10);
    link2.sel_rd_n = 1'h0;
    fork
      count_beats(8, 4);
      begin
        repeat (2) @(negedge mclk);
        link2.sel_rd_n = 1'h1;
      end
    join
    count_beats(6, 0);
    bp = {18'h04403, 18'h04402, 18'h04401, 18'h04400};
    bare_cmd(1'h1, 1'h0, 8'h11, q);
    fork
      count_beats(8, 4);
      bare_cmd(1'h0, 1'h0, 8'h22, q);
    join
    chk("bare_rd_both", q, bp);
    bare_cmd(1'h0, 1'h1, 8'h33, q);
    chk("bare_rd_after", q, bp);
    results();
  end
endmodule
